// ---- rtl/serial_config_port.sv ----
`timescale 1ns/1ps
module serial_config_port #(
  parameter int unsigned ADDR_W = cfg_port_pkg::ADDR_W,
  parameter int unsigned DATA_W = cfg_port_pkg::DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              hardware_reset_n_i,
  input  wire logic              serial_select_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdio_i,
  output logic                   sdio_o,
  output logic                   sdio_oe_n_o,
  output logic                   serial_data_out_o,
  output logic                   serial_data_out_oe_n_o,
  output logic                   four_wire_o,
  input  wire logic [ADDR_W-1:0] cfg_addr_i,
  output logic      [DATA_W-1:0] cfg_data_o
);

  logic [3:0]                    pin_level;
  logic [3:0]                    pin_rise;
  logic [3:0]                    pin_fall;
  logic                          hw_rst_n_s;
  logic                          sel_active;
  logic                          sdio_s;
  logic                          sclk_rise;
  logic                          sclk_fall;
  logic                          take_bit;
  logic                          reading;
  logic                          commit;
  logic                          soft_reset;
  logic                          hw_reset_req;
  logic [DATA_W-1:0]             wr_data;
  logic [ADDR_W-1:0]             rx_addr;
  cfg_port_pkg::state_e          state_q;
  logic [cfg_port_pkg::CNT_W-1:0] bit_cnt_q;
  logic [cfg_port_pkg::SHIFT_W-1:0] shift_q;
  logic                          rw_q;
  logic                          lock_q;
  logic [ADDR_W-1:0]             addr_q;
  logic [DATA_W-1:0]             tx_q;
  logic [DATA_W-1:0]             regs_q [cfg_port_pkg::REG_COUNT];

  // order: {reset pin, select, shift clock, data}
  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (cfg_port_pkg::PIN_RESET_VAL)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({hardware_reset_n_i, serial_select_n_i, sclk_i, sdio_i}),
    .level_o (pin_level),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  assign hw_rst_n_s   = pin_level[3];
  assign sel_active   = ~pin_level[2];
  assign sclk_rise    = pin_rise[1];
  assign sclk_fall    = pin_fall[1];
  assign sdio_s       = pin_level[0];
  assign hw_reset_req = ~hw_rst_n_s;

  // a bit is taken on every rise while selected, until the frame is full
  assign take_bit = sel_active && sclk_rise && (state_q != cfg_port_pkg::HOLD);
  assign rx_addr  = {shift_q[5:0], sdio_s};
  assign wr_data  = {shift_q[14:0], sdio_s};
  assign reading  = (state_q == cfg_port_pkg::DATA) && rw_q;
  assign commit   = take_bit && (bit_cnt_q == cfg_port_pkg::LAST_FRAME_IDX)
                    && !rw_q && !lock_q;
  assign soft_reset = commit && (addr_q == cfg_port_pkg::SOFT_RESET_REG);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cfg_port_pkg::IDLE;
    end else if (!sel_active) begin
      state_q <= cfg_port_pkg::IDLE;
    end else begin
      case (state_q)
        cfg_port_pkg::IDLE: begin
          state_q <= cfg_port_pkg::ADDR;
        end
        cfg_port_pkg::ADDR: begin
          if (take_bit && bit_cnt_q == cfg_port_pkg::LAST_ADDR_IDX) begin
            state_q <= cfg_port_pkg::DATA;
          end
        end
        cfg_port_pkg::DATA: begin
          if (take_bit && bit_cnt_q == cfg_port_pkg::LAST_FRAME_IDX) begin
            state_q <= cfg_port_pkg::HOLD;
          end
        end
        default: begin
          state_q <= cfg_port_pkg::HOLD;
        end
      endcase
    end
  end

  // counting also in idle catches a clock edge that lands with select
  always_ff @(posedge clk_i) begin
    if (rst_i || !sel_active) begin
      bit_cnt_q <= '0;
    end else if (take_bit) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
    end else if (take_bit) begin
      shift_q <= {shift_q[cfg_port_pkg::SHIFT_W-2:0], sdio_s};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rw_q <= 1'b0;
    end else if (take_bit && bit_cnt_q == cfg_port_pkg::RW_BIT_IDX) begin
      rw_q <= sdio_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (take_bit && bit_cnt_q == cfg_port_pkg::RW_BIT_IDX) begin
      lock_q <= sdio_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
    end else if (take_bit && bit_cnt_q == cfg_port_pkg::LAST_ADDR_IDX) begin
      addr_q <= rx_addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q <= '0;
    end else if (take_bit && bit_cnt_q == cfg_port_pkg::LAST_ADDR_IDX && rw_q) begin
      tx_q <= regs_q[rx_addr];
    end else if (sclk_fall && reading && bit_cnt_q > cfg_port_pkg::FIRST_DATA_CNT) begin
      tx_q <= {tx_q[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hw_reset_req || soft_reset) begin
      for (int i = 0; i < cfg_port_pkg::REG_COUNT; i++) begin
        regs_q[i] <= cfg_port_pkg::reg_default(7'(i));
      end
    end else if (commit) begin
      regs_q[addr_q] <= wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_data_o <= '0;
    end else begin
      cfg_data_o <= regs_q[cfg_addr_i];
    end
  end

  assign four_wire_o = regs_q[cfg_port_pkg::MODE_REG][cfg_port_pkg::MODE_BIT];

  assign sdio_o            = tx_q[DATA_W-1];
  assign serial_data_out_o = tx_q[DATA_W-1];
  assign sdio_oe_n_o            = !(reading && !four_wire_o);
  assign serial_data_out_oe_n_o = !(reading && four_wire_o);

  rw_capture_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_bit && bit_cnt_q == cfg_port_pkg::RW_BIT_IDX) |=> (rw_q == $past(sdio_s)))
    else $error("read/write flag not taken on first rise");

  flag_position_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (take_bit && bit_cnt_q == cfg_port_pkg::LAST_ADDR_IDX) |=> (rw_q == $past(shift_q[6])))
    else $error("flag is not the top bit of the address word");

  frame_length_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    commit |-> (state_q == cfg_port_pkg::DATA && bit_cnt_q == cfg_port_pkg::LAST_FRAME_IDX))
    else $error("write committed before twenty-four bits");

  write_store_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (commit && !soft_reset && hw_rst_n_s) |=> (regs_q[$past(addr_q)] == $past(wr_data)))
    else $error("written word not stored");

  soft_reset_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    soft_reset |=> (regs_q[cfg_port_pkg::SOFT_RESET_REG] == cfg_port_pkg::ZERO_DEFAULT
                    && regs_q[cfg_port_pkg::CORR_A_REG] == cfg_port_pkg::CORR_DEFAULT))
    else $error("soft reset did not restore defaults");

  pin_reset_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hw_reset_req |=> (regs_q[cfg_port_pkg::OVR_REG] == cfg_port_pkg::OVR_DEFAULT
                      && !four_wire_o))
    else $error("reset pin did not restore defaults");

  read_lock_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    // the addressed register must not move during a read frame
    (rw_q && state_q == cfg_port_pkg::DATA && !hw_reset_req)
      |=> (regs_q[addr_q] == $past(regs_q[addr_q])))
    else $error("write taken while read flag set");

  three_pin_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!four_wire_o && reading) |-> (!sdio_oe_n_o && serial_data_out_oe_n_o))
    else $error("three-pin read not on shared data pin");

  four_pin_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    four_wire_o |-> sdio_oe_n_o)
    else $error("shared data pin driven in four-pin mode");

  read_order_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sclk_fall && reading && bit_cnt_q > cfg_port_pkg::FIRST_DATA_CNT)
      |=> (sdio_o == $past(tx_q[14])))
    else $error("readback bit order broken");

  select_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !sel_active |=> (state_q == cfg_port_pkg::IDLE && bit_cnt_q == '0))
    else $error("frame not ended by select high");

  write_seen_c: cover property (@(posedge clk_i) disable iff (rst_i) commit);
  read_seen_c: cover property (@(posedge clk_i) disable iff (rst_i)
    reading && sclk_fall);
  soft_reset_c: cover property (@(posedge clk_i) disable iff (rst_i) soft_reset);
  four_wire_c: cover property (@(posedge clk_i) disable iff (rst_i)
    four_wire_o && reading);

endmodule : serial_config_port

// ---- rtl/cfg_port_pkg.sv ----
package cfg_port_pkg;

  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned REG_COUNT = 128;
  localparam int unsigned CNT_W     = 5;
  localparam int unsigned SHIFT_W   = 24;

  // bit counter values, counted in rising shift-clock edges since select fell
  localparam logic [4:0] RW_BIT_IDX     = 5'h00;
  localparam logic [4:0] LAST_ADDR_IDX  = 5'h07;
  localparam logic [4:0] FIRST_DATA_CNT = 5'h08;
  localparam logic [4:0] LAST_FRAME_IDX = 5'h17;

  // position of the read/write flag inside the received address word
  localparam int unsigned RW_FLAG_POS = 7;

  localparam logic [6:0] MODE_REG       = 7'h00;
  localparam int unsigned MODE_BIT      = 15;
  localparam logic [6:0] OVR_REG        = 7'h02;
  localparam logic [6:0] CORR_A_REG     = 7'h03;
  localparam logic [6:0] CORR_B_REG     = 7'h1a;
  localparam logic [6:0] SOFT_RESET_REG = 7'h2c;

  localparam logic [15:0] OVR_DEFAULT  = 16'h0780;
  localparam logic [15:0] CORR_DEFAULT = 16'h0b18;
  localparam logic [15:0] ZERO_DEFAULT = 16'h0000;

  localparam logic [3:0] PIN_RESET_VAL = 4'hc;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ADDR = 2'b01,
    DATA = 2'b11,
    HOLD = 2'b10
  } state_e;

  function automatic logic [15:0] reg_default(input logic [6:0] a);
    logic [15:0] v;
    v = ZERO_DEFAULT;
    if (a == OVR_REG) begin
      v = OVR_DEFAULT;
    end else if (a == CORR_A_REG || a == CORR_B_REG) begin
      v = CORR_DEFAULT;
    end
    return v;
  endfunction : reg_default

endpackage : cfg_port_pkg

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned      WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= RESET_VAL;
    end else begin
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;

endmodule : pin_sync

// ---- tb/cfg_ctrl_model.sv ----
`timescale 1ns/1ps
module cfg_ctrl_model (
  input  wire logic clk_i,
  input  wire logic sdio_line_i,
  input  wire logic sdo_line_i,
  input  wire logic four_wire_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdio_o
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdio_o  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold

  // shift clock only runs inside a frame; nbits below 24 makes a cut frame
  // flag, address, data msb first
  task automatic frame(input logic rw, input logic [6:0] a, input logic [15:0] wd,
                       input int nbits, output logic [15:0] rd);
    logic [23:0] word;
    word = {rw, a, wd};
    rd = 16'h0000;
    hold(1);
    sel_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      // released line toggles so a stale level never looks like data
      sdio_o = (rw && i >= 8) ? ~sdio_o : word[23-i];
      hold(4);
      sclk_o = 1'b1;
      if (i >= 8) rd = {rd[14:0], four_wire_i ? sdo_line_i : sdio_line_i};
      hold(4);
      sclk_o = 1'b0;
    end
    hold(4);
    sel_n_o = 1'b1;
    hold(4);
  endtask : frame
endmodule : cfg_ctrl_model

// ---- tb/test_serial_config_port.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module test_serial_config_port;
  logic        clk_i, rst_i, hw_rst_n, sel_n, sclk, ctrl_sdio, sdio_q, sdio_oe_n;
  logic        serial_data_out, sdo_oe_n, four_wire, toggle;
  logic [6:0]  cfg_addr;
  logic [15:0] cfg_data, rd;
  int          err_total, checked, sdio_in_4w;
  wire         sdio_line = sdio_oe_n ? ctrl_sdio : sdio_q;
  wire         sdo_line  = sdo_oe_n ? toggle : serial_data_out;

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) toggle <= ~toggle;
  // an unknown enable counts as driven, so it cannot slip through
  always @(posedge clk_i) if (four_wire !== 1'b0 && sdio_oe_n !== 1'b1) sdio_in_4w++;

  serial_config_port serial_config_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .hardware_reset_n_i(hw_rst_n),
    .serial_select_n_i(sel_n), .sclk_i(sclk), .sdio_i(sdio_line),
    .sdio_o(sdio_q), .sdio_oe_n_o(sdio_oe_n), .serial_data_out_o(serial_data_out),
    .serial_data_out_oe_n_o(sdo_oe_n), .four_wire_o(four_wire),
    .cfg_addr_i(cfg_addr), .cfg_data_o(cfg_data));

  cfg_ctrl_model cfg_ctrl_model_inst (
    .clk_i(clk_i), .sdio_line_i(sdio_line), .sdo_line_i(sdo_line),
    .four_wire_i(four_wire), .sel_n_o(sel_n), .sclk_o(sclk), .sdio_o(ctrl_sdio));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  task automatic core_is(input logic [6:0] a, input logic [15:0] exp);
    @(negedge clk_i) cfg_addr = a;
    repeat (2) @(negedge clk_i);
    `CHK(cfg_data, exp)
  endtask : core_is

  task automatic pin_pulse;
    hw_rst_n = 1'b0;
    repeat (4) @(negedge clk_i);
    hw_rst_n = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : pin_pulse

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    cfg_ctrl_model_inst.frame(1'b0, a, d, 24, rd);
  endtask : wr

  task automatic sread(input logic [6:0] a, input logic [15:0] exp);
    cfg_ctrl_model_inst.frame(1'b1, a, 16'hffff, 24, rd);
    `CHK(rd, exp)
  endtask : sread

  task automatic t_defaults;
    core_is(7'h02, 16'h0780);
    core_is(7'h03, 16'h0b18);
    core_is(7'h1a, 16'h0b18);
    core_is(7'h00, 16'h0000);
    `CHK(four_wire, 1'b0)
    sread(7'h02, 16'h0780);
    $display("t_defaults done");
  endtask : t_defaults

  task automatic t_write_read;
    wr(7'h05, 16'ha5c3);
    core_is(7'h05, 16'ha5c3);
    sread(7'h05, 16'ha5c3);
    core_is(7'h05, 16'ha5c3);
    wr(7'h06, 16'h5a3c);
    core_is(7'h06, 16'h5a3c);
    $display("t_write_read done");
  endtask : t_write_read

  task automatic t_partial;
    cfg_ctrl_model_inst.frame(1'b0, 7'h05, 16'h1234, 20, rd);
    core_is(7'h05, 16'ha5c3);
    $display("t_partial done");
  endtask : t_partial

  task automatic t_four_wire;
    wr(7'h00, 16'h8000);
    `CHK(four_wire, 1'b1)
    sdio_in_4w = 0;
    sread(7'h05, 16'ha5c3);
    `CHK(sdio_in_4w, 0)
    $display("t_four_wire done");
  endtask : t_four_wire

  task automatic t_soft_reset;
    wr(7'h2c, 16'h0001);
    core_is(7'h05, 16'h0000);
    core_is(7'h2c, 16'h0000);
    core_is(7'h02, 16'h0780);
    `CHK(four_wire, 1'b0)
    $display("t_soft_reset done");
  endtask : t_soft_reset

  task automatic t_pin_reset;
    wr(7'h07, 16'h1111);
    core_is(7'h07, 16'h1111);
    pin_pulse;
    core_is(7'h07, 16'h0000);
    core_is(7'h1a, 16'h0b18);
    $display("t_pin_reset done");
  endtask : t_pin_reset

  initial begin
    #1000000;
    err_total++;
    $display("[ERR] %0t run limit reached", $time);
    give_verdict;
  end

  initial begin
    rst_i = 1'b1;
    hw_rst_n = 1'b1;
    cfg_addr = 7'h00;
    toggle = 1'b0;
    err_total = 0;
    checked = 0;
    sdio_in_4w = 0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    pin_pulse;
    t_defaults;
    t_write_read;
    t_partial;
    t_four_wire;
    t_soft_reset;
    t_pin_reset;
    give_verdict;
  end
endmodule : test_serial_config_port
